//--- bat_regs_params.svh
// Offsets, field positions, reset values and bus constants of the charge status register bank
`ifndef BAT_REGS_PARAMS_SVH
`define BAT_REGS_PARAMS_SVH

// Register offsets on the two-wire management bus
`define OFS_PATH_CTRL        8'h19
`define OFS_TEMP_REGION_CTRL 8'h1C
`define OFS_REV_TEMP_CTRL    8'h1D
`define OFS_REV_UV_CTRL      8'h1E
`define OFS_STATUS_ONE       8'h21
`define OFS_STATUS_TWO       8'h22

// Reset values
`define RST_TEMP_REGION_CTRL 8'h57
`define RST_REV_TEMP_CTRL    8'h40
`define RST_REV_UV_CTRL      8'h00
`define RST_STATUS_ONE       8'h08
`define RST_STATUS_TWO       8'h00

// Field positions
`define POS_REG_RESET        7
`define POS_WARM_VSET_HI     6
`define POS_WARM_VSET_LO     5
`define POS_WARM_ISET        4
`define POS_COOL_ISET_HI     3
`define POS_COOL_ISET_LO     2
`define POS_PROFILE_EN       1
`define POS_THERM_EN         0
`define POS_REV_HOT_HI       7
`define POS_REV_HOT_LO       6
`define POS_REV_COLD         5
`define POS_REV_UV           5

// Field codes
`define CODE_SUSPEND         2'h0
`define CODE_CUR_40          2'h2
`define CODE_FULL            2'h3
`define CODE_REV_HOT_OFF     2'h3

// Bus framing
`define DEV_ADDR_DEFAULT     7'h6B
`define BITS_PER_BYTE        4'h8

`endif

//--- bat_regs_pkg.sv
// Types shared by the charge status register bank
package bat_regs_pkg;

	typedef enum logic [3:0] {
		ST_IDLE      = 4'h0,
		ST_ADDR      = 4'h1,
		ST_ADDR_ACK  = 4'h2,
		ST_PTR       = 4'h3,
		ST_PTR_ACK   = 4'h4,
		ST_WDATA     = 4'h5,
		ST_WDATA_ACK = 4'h6,
		ST_RDATA     = 4'h7,
		ST_RDATA_ACK = 4'h8
	} link_state_t;

	typedef enum logic [2:0] {
		TS_NORMAL = 3'h0,
		TS_WARM   = 3'h1,
		TS_COOL   = 3'h2,
		TS_COLD   = 3'h3,
		TS_HOT    = 3'h4
	} ts_region_t;

endpackage : bat_regs_pkg

//--- battery_temp_and_charge_status_regs.sv
// Temperature control, reverse-mode control and charger status registers behind a two-wire bus
`include "bat_regs_params.svh"
`timescale 1ns/1ps

module battery_temp_and_charge_status_regs
	import bat_regs_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = `DEV_ADDR_DEFAULT
) (
	input  wire logic       clk_sys,
	input  wire logic       arst_n,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	input  wire logic       adc_done,
	input  wire logic       input_current_limit_active,
	input  wire logic       input_voltage_limit_active,
	input  wire logic       watchdog_expired,
	input  wire logic [2:0] charge_phase,
	input  wire logic       power_good,
	input  wire logic [2:0] thermistor_region,
	input  wire logic [1:0] warm_threshold_select,
	output logic            charge_enable,
	output logic [1:0]      voltage_target_code,
	output logic [1:0]      current_target_code,
	output logic            thermistor_monitor_enable,
	output logic [1:0]      reverse_hot_code,
	output logic            reverse_hot_check_enable,
	output logic            reverse_cold_select,
	output logic            reverse_uv_fixed,
	output logic [1:0]      warm_boundary_code
);

	// Pin synchronisers; the third stage of each bus line only feeds edge detection
	logic [1:0] scl_sync;
	logic [1:0] sda_sync;
	logic       scl_prev;
	logic       sda_prev;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			scl_sync <= 2'h3;
			sda_sync <= 2'h3;
			scl_prev <= 1'b1;
			sda_prev <= 1'b1;
		end else begin
			scl_sync <= {scl_sync[0], scl_in};
			sda_sync <= {sda_sync[0], sda_in};
			scl_prev <= scl_sync[1];
			sda_prev <= sda_sync[1];
		end
	end

	logic scl_s;
	logic sda_s;
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;

	assign scl_s     = scl_sync[1];
	assign sda_s     = sda_sync[1];
	assign scl_rise  = scl_s & ~scl_prev;
	assign scl_fall  = ~scl_s & scl_prev;
	assign bus_start = scl_s & scl_prev & sda_prev & ~sda_s;
	assign bus_stop  = scl_s & scl_prev & ~sda_prev & sda_s;

	// Status inputs come from the analog side, so two stages each
	logic [1:0] adc_done_sync;
	logic [1:0] icl_sync;
	logic [1:0] vil_sync;
	logic [1:0] wd_sync;
	logic [1:0] pg_sync;
	logic [2:0] phase_meta;
	logic [2:0] phase_s;
	logic [2:0] region_meta;
	logic [2:0] region_s;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			adc_done_sync <= 2'h0;
			icl_sync      <= 2'h0;
			vil_sync      <= 2'h0;
			wd_sync       <= 2'h3;
			pg_sync       <= 2'h0;
			phase_meta    <= 3'h0;
			phase_s       <= 3'h0;
			region_meta   <= 3'h0;
			region_s      <= 3'h0;
		end else begin
			adc_done_sync <= {adc_done_sync[0], adc_done};
			icl_sync      <= {icl_sync[0], input_current_limit_active};
			vil_sync      <= {vil_sync[0], input_voltage_limit_active};
			wd_sync       <= {wd_sync[0], watchdog_expired};
			pg_sync       <= {pg_sync[0], power_good};
			phase_meta    <= charge_phase;
			phase_s       <= phase_meta;
			region_meta   <= thermistor_region;
			region_s      <= region_meta;
		end
	end

	// Writable fields
	logic [1:0] warm_voltage_select;
	logic       warm_current_select;
	logic [1:0] cool_current_select;
	logic       four_region_profile_enable;
	logic       thermistor_function_enable;
	logic [1:0] reverse_hot_select;
	logic       reverse_cold_threshold;
	logic       reverse_system_uv_select;

	// Register read image; unmapped offsets and reserved bits read zero
	function automatic logic [7:0] read_reg(input logic [7:0] ofs);
		logic [7:0] val;
		val = 8'h00;
		unique case (ofs)
			`OFS_TEMP_REGION_CTRL: begin
				val[`POS_WARM_VSET_HI:`POS_WARM_VSET_LO] = warm_voltage_select;
				val[`POS_WARM_ISET]                      = warm_current_select;
				val[`POS_COOL_ISET_HI:`POS_COOL_ISET_LO] = cool_current_select;
				val[`POS_PROFILE_EN]                     = four_region_profile_enable;
				val[`POS_THERM_EN]                       = thermistor_function_enable;
			end
			`OFS_REV_TEMP_CTRL: begin
				val[`POS_REV_HOT_HI:`POS_REV_HOT_LO] = reverse_hot_select;
				val[`POS_REV_COLD]                   = reverse_cold_threshold;
			end
			`OFS_REV_UV_CTRL: begin
				val[`POS_REV_UV] = reverse_system_uv_select;
			end
			`OFS_STATUS_ONE: begin
				val = {adc_done_sync[1], icl_sync[1], vil_sync[1], 1'b0, wd_sync[1], phase_s};
			end
			`OFS_STATUS_TWO: begin
				val = {pg_sync[1], region_s, 4'h0};
			end
			default: begin
				val = 8'h00;
			end
		endcase
		return val;
	endfunction : read_reg

	// Bus protocol engine
	link_state_t state;
	logic [3:0]  bit_cnt;
	logic [7:0]  rx_shift;
	logic [7:0]  tx_shift;
	logic [7:0]  reg_ptr;
	logic        read_dir;
	logic        host_ack;
	logic        wr_pulse;
	logic [7:0]  wr_ofs;
	logic [7:0]  wr_data;
	logic [7:0]  next_tx;

	assign next_tx = read_reg(reg_ptr);

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state    <= ST_IDLE;
			bit_cnt  <= 4'h0;
			rx_shift <= 8'h00;
			tx_shift <= 8'h00;
			reg_ptr  <= 8'h00;
			read_dir <= 1'b0;
			host_ack <= 1'b0;
			wr_pulse <= 1'b0;
			wr_ofs   <= 8'h00;
			wr_data  <= 8'h00;
			sda_oe   <= 1'b0;
			sda_out  <= 1'b0;
		end else begin
			wr_pulse <= 1'b0;
			sda_out  <= 1'b0;
			if (bus_start) begin
				state   <= ST_ADDR;
				bit_cnt <= 4'h0;
				sda_oe  <= 1'b0;
			end else if (bus_stop) begin
				state  <= ST_IDLE;
				sda_oe <= 1'b0;
			end else begin
				unique case (state)
					ST_IDLE: begin
						sda_oe <= 1'b0;
					end
					ST_ADDR, ST_PTR, ST_WDATA: begin
						if (scl_rise) begin
							rx_shift <= {rx_shift[6:0], sda_s};
							bit_cnt  <= bit_cnt + 4'h1;
						end else if (scl_fall && bit_cnt == `BITS_PER_BYTE) begin
							bit_cnt <= 4'h0;
							unique case (state)
								ST_ADDR: begin
									if (rx_shift[7:1] == DEV_ADDR) begin
										read_dir <= rx_shift[0];
										sda_oe   <= 1'b1;
										state    <= ST_ADDR_ACK;
									end else begin
										state <= ST_IDLE;
									end
								end
								ST_PTR: begin
									reg_ptr <= rx_shift;
									sda_oe  <= 1'b1;
									state   <= ST_PTR_ACK;
								end
								default: begin
									wr_pulse <= 1'b1;
									wr_ofs   <= reg_ptr;
									wr_data  <= rx_shift;
									reg_ptr  <= reg_ptr + 8'h01;
									sda_oe   <= 1'b1;
									state    <= ST_WDATA_ACK;
								end
							endcase
						end
					end
					ST_ADDR_ACK: begin
						if (scl_fall) begin
							bit_cnt <= 4'h0;
							if (read_dir) begin
								tx_shift <= next_tx;
								sda_oe   <= ~next_tx[7];
								state    <= ST_RDATA;
							end else begin
								sda_oe <= 1'b0;
								state  <= ST_PTR;
							end
						end
					end
					ST_PTR_ACK, ST_WDATA_ACK: begin
						if (scl_fall) begin
							bit_cnt <= 4'h0;
							sda_oe  <= 1'b0;
							state   <= ST_WDATA;
						end
					end
					ST_RDATA: begin
						if (scl_rise) begin
							bit_cnt <= bit_cnt + 4'h1;
						end else if (scl_fall) begin
							if (bit_cnt == `BITS_PER_BYTE) begin
								sda_oe  <= 1'b0;
								reg_ptr <= reg_ptr + 8'h01;
								state   <= ST_RDATA_ACK;
							end else begin
								tx_shift <= {tx_shift[6:0], 1'b0};
								sda_oe   <= ~tx_shift[6];
							end
						end
					end
					ST_RDATA_ACK: begin
						if (scl_rise) begin
							host_ack <= ~sda_s;
						end else if (scl_fall) begin
							bit_cnt <= 4'h0;
							if (host_ack) begin
								tx_shift <= next_tx;
								sda_oe   <= ~next_tx[7];
								state    <= ST_RDATA;
							end else begin
								state <= ST_IDLE;
							end
						end
					end
					default: begin
						state  <= ST_IDLE;
						sda_oe <= 1'b0;
					end
				endcase
			end
		end
	end

	// Register writes; the reset bit is never stored, so it always reads back zero
	logic reg_reset_hit;

	assign reg_reset_hit = wr_pulse && wr_ofs == `OFS_PATH_CTRL && wr_data[`POS_REG_RESET];

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			{warm_voltage_select, warm_current_select, cool_current_select,
				four_region_profile_enable, thermistor_function_enable} <= 7'(`RST_TEMP_REGION_CTRL);
			reverse_hot_select       <= 2'(`RST_REV_TEMP_CTRL >> `POS_REV_HOT_LO);
			reverse_cold_threshold   <= 1'b0;
			reverse_system_uv_select <= 1'b0;
		end else if (reg_reset_hit) begin
			{warm_voltage_select, warm_current_select, cool_current_select,
				four_region_profile_enable, thermistor_function_enable} <= 7'(`RST_TEMP_REGION_CTRL);
			reverse_hot_select       <= 2'(`RST_REV_TEMP_CTRL >> `POS_REV_HOT_LO);
			reverse_cold_threshold   <= 1'b0;
			reverse_system_uv_select <= 1'b0;
		end else if (wr_pulse) begin
			unique case (wr_ofs)
				`OFS_TEMP_REGION_CTRL: begin
					warm_voltage_select        <= wr_data[`POS_WARM_VSET_HI:`POS_WARM_VSET_LO];
					warm_current_select        <= wr_data[`POS_WARM_ISET];
					cool_current_select        <= wr_data[`POS_COOL_ISET_HI:`POS_COOL_ISET_LO];
					four_region_profile_enable <= wr_data[`POS_PROFILE_EN];
					thermistor_function_enable <= wr_data[`POS_THERM_EN];
				end
				`OFS_REV_TEMP_CTRL: begin
					reverse_hot_select     <= wr_data[`POS_REV_HOT_HI:`POS_REV_HOT_LO];
					reverse_cold_threshold <= wr_data[`POS_REV_COLD];
				end
				`OFS_REV_UV_CTRL: begin
					reverse_system_uv_select <= wr_data[`POS_REV_UV];
				end
				default: begin
				end
			endcase
		end
	end

	// Effective charge targets from region and settings
	logic [1:0] next_vcode;
	logic [1:0] next_icode;
	ts_region_t region;

	assign region = ts_region_t'(region_s);

	always_comb begin
		next_vcode = `CODE_FULL;
		next_icode = `CODE_FULL;
		if (thermistor_function_enable) begin
			if (region == TS_COLD || region == TS_HOT) begin
				next_vcode = `CODE_SUSPEND;
				next_icode = `CODE_SUSPEND;
			end else if (four_region_profile_enable && region == TS_WARM) begin
				next_vcode = warm_voltage_select;
				next_icode = warm_current_select ? `CODE_FULL : `CODE_CUR_40;
			end else if (four_region_profile_enable && region == TS_COOL) begin
				next_icode = cool_current_select;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			charge_enable       <= 1'b0;
			voltage_target_code <= `CODE_FULL;
			current_target_code <= `CODE_FULL;
		end else begin
			// Suspend in either code stops charging outright
			charge_enable       <= next_vcode != `CODE_SUSPEND && next_icode != `CODE_SUSPEND;
			voltage_target_code <= next_vcode;
			current_target_code <= next_icode;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			thermistor_monitor_enable <= 1'b0;
			reverse_hot_code          <= 2'h0;
			reverse_hot_check_enable  <= 1'b0;
			reverse_cold_select       <= 1'b0;
			reverse_uv_fixed          <= 1'b0;
			warm_boundary_code        <= 2'h0;
		end else begin
			thermistor_monitor_enable <= thermistor_function_enable;
			reverse_hot_code          <= reverse_hot_select;
			reverse_hot_check_enable  <= thermistor_function_enable
				&& reverse_hot_select != `CODE_REV_HOT_OFF;
			reverse_cold_select       <= reverse_cold_threshold;
			reverse_uv_fixed          <= reverse_system_uv_select;
			warm_boundary_code        <= warm_threshold_select;
		end
	end

endmodule : battery_temp_and_charge_status_regs

//--- bat_host_model.sv
// Two-wire bus host model that drives the register bank's bus pins
`timescale 1ns/1ps

module bat_host_model (
	input  wire logic clk_sys,
	output logic      scl,
	output logic      sda_pull,
	input  wire logic sda_wire
);
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end

	task automatic wt(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : wt

	// Ten clocks a phase keeps well clear of the four-clock sync minimum
	task automatic bit_io(input logic b, output logic r);
		wt(3);
		sda_pull <= ~b;
		wt(10);
		scl <= 1'b1;
		wt(10);
		r = sda_wire;
		scl <= 1'b0;
	endtask : bit_io

	task automatic start();
		wt(3);
		sda_pull <= 1'b0;
		wt(10);
		scl <= 1'b1;
		wt(10);
		sda_pull <= 1'b1;
		wt(10);
		scl <= 1'b0;
	endtask : start

	task automatic stop();
		wt(3);
		sda_pull <= 1'b1;
		wt(10);
		scl <= 1'b1;
		wt(10);
		sda_pull <= 1'b0;
		wt(10);
	endtask : stop

	task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
		output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
			q[i] = r;
		end
		bit_io(ack_in, r);
		ack = ~r;
	endtask : xfer
endmodule : bat_host_model

//--- bat_regs_assertions.sv
// Port-level assertions for the temperature and charge status register bank
`timescale 1ns/1ps

module bat_regs_checker (
	input wire logic       clk_sys,
	input wire logic       arst_n,
	input wire logic       scl_in,
	input wire logic       sda_oe,
	input wire logic [2:0] thermistor_region,
	input wire logic [1:0] warm_threshold_select,
	input wire logic       charge_enable,
	input wire logic [1:0] voltage_target_code,
	input wire logic [1:0] current_target_code,
	input wire logic       thermistor_monitor_enable,
	input wire logic [1:0] reverse_hot_code,
	input wire logic       reverse_hot_check_enable,
	input wire logic [1:0] warm_boundary_code
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!arst_n);

	// Region pin takes 3 clocks to reach targets; 5 leaves margin
	property p_normal;
		thermistor_region == 3'h0 [*5] |-> charge_enable && voltage_target_code == 2'h3
			&& current_target_code == 2'h3;
	endproperty
	a_normal: assert property (p_normal) else $error("normal region not full target");
	property p_cold;
		(thermistor_region == 3'h3 && thermistor_monitor_enable) [*5] |-> !charge_enable;
	endproperty
	a_cold: assert property (p_cold) else $error("charging in cold region");
	property p_hot;
		(thermistor_region == 3'h4 && thermistor_monitor_enable) [*5] |-> !charge_enable;
	endproperty
	a_hot: assert property (p_hot) else $error("charging in hot region");
	property p_ts_off;
		!thermistor_monitor_enable [*4] |-> charge_enable && voltage_target_code == 2'h3
			&& current_target_code == 2'h3;
	endproperty
	a_ts_off: assert property (p_ts_off) else $error("thermistor off but targets cut");
	property p_suspend;
		voltage_target_code == 2'h0 || current_target_code == 2'h0 |-> !charge_enable;
	endproperty
	a_suspend: assert property (p_suspend) else $error("suspend code with charge on");
	property p_rev_hot;
		reverse_hot_check_enable == (thermistor_monitor_enable && reverse_hot_code != 2'h3);
	endproperty
	a_rev_hot: assert property (p_rev_hot) else $error("hot check enable wrong");
	property p_warm_bnd;
		$changed(warm_threshold_select) |=> warm_boundary_code == $past(warm_threshold_select);
	endproperty
	a_warm_bnd: assert property (p_warm_bnd) else $error("warm boundary not loaded");
	// Data may only move while the bus clock is low, else it reads as a start or stop
	property p_sda_timing;
		$changed(sda_oe) |-> !scl_in && !$past(scl_in, 2);
	endproperty
	a_sda_timing: assert property (p_sda_timing) else $error("data moved with clock high");

	c_warm: cover property (thermistor_region == 3'h1 && charge_enable);
	c_cold: cover property (thermistor_region == 3'h3 && !charge_enable);
	c_hot_off: cover property (reverse_hot_code == 2'h3 && !reverse_hot_check_enable);
endmodule : bat_regs_checker

bind battery_temp_and_charge_status_regs bat_regs_checker u_chk (
	.clk_sys                  (clk_sys),
	.arst_n                   (arst_n),
	.scl_in                   (scl_in),
	.sda_oe                   (sda_oe),
	.thermistor_region        (thermistor_region),
	.warm_threshold_select    (warm_threshold_select),
	.charge_enable            (charge_enable),
	.voltage_target_code      (voltage_target_code),
	.current_target_code      (current_target_code),
	.thermistor_monitor_enable(thermistor_monitor_enable),
	.reverse_hot_code         (reverse_hot_code),
	.reverse_hot_check_enable (reverse_hot_check_enable),
	.warm_boundary_code       (warm_boundary_code)
);

//--- tb_battery_temp_and_charge_status_regs.sv
// Self-checking testbench for the temperature and charge status register bank
`timescale 1ns/1ps

module tb_battery_temp_and_charge_status_regs;
	logic       clk_sys, arst_n, scl, sda_pull, sda_wire, sda_oe, sda_o, a;
	logic       adc_done, icl, ivl, wd, pg, ce, tme, hot_en, cold_sel, uv_fix;
	logic [2:0] phase, region, b, rg;
	logic [1:0] wts, vcode, ccode, hot_code, wbc;
	logic [7:0] d;
	int         errors, tests_run;

	// Open drain with pull-up: low if either side pulls
	assign sda_wire = ~(sda_oe | sda_pull);

	battery_temp_and_charge_status_regs dut (
		.clk_sys(clk_sys), .arst_n(arst_n), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_o),
		.sda_oe(sda_oe), .adc_done(adc_done), .input_current_limit_active(icl),
		.input_voltage_limit_active(ivl), .watchdog_expired(wd), .charge_phase(phase),
		.power_good(pg), .thermistor_region(region), .warm_threshold_select(wts),
		.charge_enable(ce), .voltage_target_code(vcode), .current_target_code(ccode),
		.thermistor_monitor_enable(tme), .reverse_hot_code(hot_code),
		.reverse_hot_check_enable(hot_en), .reverse_cold_select(cold_sel),
		.reverse_uv_fixed(uv_fix), .warm_boundary_code(wbc));

	bat_host_model host (.clk_sys(clk_sys), .scl(scl), .sda_pull(sda_pull), .sda_wire(sda_wire));

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] ofs, input logic [7:0] v);
		logic [7:0] q;
		logic       a0, a1, a2;
		host.start();
		host.xfer(8'hD6, 1'b1, q, a0);
		host.xfer(ofs, 1'b1, q, a1);
		host.xfer(v, 1'b1, q, a2);
		host.stop();
		chk({5'h0, a0, a1, a2}, 8'h07);
	endtask : wr

	task automatic rd_chk(input logic [7:0] ofs, input logic [7:0] exp);
		logic [7:0] q, v;
		logic       a0, a1, a2, an;
		host.start();
		host.xfer(8'hD6, 1'b1, q, a0);
		host.xfer(ofs, 1'b1, q, a1);
		host.start();
		host.xfer(8'hD7, 1'b1, q, a2);
		host.xfer(8'hFF, 1'b1, v, an);
		host.stop();
		chk({5'h0, a0, a1, a2}, 8'h07);
		chk(v, exp);
	endtask : rd_chk

	// Mask hides codes that mean nothing while charging is suspended, and the voltage code in the cool region
	task automatic tgt(input logic [2:0] r, input logic [4:0] m, input logic [4:0] x);
		region <= r;
		wts <= r[1:0];
		repeat (5) @(posedge clk_sys);
		chk({wbc, 1'b0, {ce, vcode, ccode} & m}, {r[1:0], 1'b0, x & m});
	endtask : tgt

	task automatic test_done();
		$display("errors=%0d tests_run=%0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : test_done

	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	initial begin
		// Tests need about 35000 clocks; this leaves margin under the run limit
		repeat (60000) @(posedge clk_sys);
		errors++;
		test_done();
	end

	initial begin
		{adc_done, icl, ivl, pg, phase, region, wts} = '0;
		wd = 1'b1;
		arst_n = 1'b0;
		errors = 0;
		tests_run = 0;
		repeat (4) @(posedge clk_sys);
		arst_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		rd_chk(8'h1C, 8'h57);
		rd_chk(8'h1D, 8'h40);
		rd_chk(8'h1E, 8'h00);
		rd_chk(8'h21, 8'h08);
		rd_chk(8'h22, 8'h00);
		$display("test reset_values done");
		for (int i = 0; i < 8; i++) begin
			b = i[2:0];
			rg = (i < 5) ? b : b - 3'h5;
			{adc_done, icl, ivl, wd, pg} <= {b, ~b[0], b[1]};
			phase <= b;
			region <= rg;
			rd_chk(8'h21, {b, 1'b0, ~b[0], b});
			rd_chk(8'h22, {b[1], rg, 4'h0});
		end
		$display("test status done");
		wr(8'h1C, 8'hFF);
		rd_chk(8'h1C, 8'h7F);
		wr(8'h1D, 8'hFF);
		rd_chk(8'h1D, 8'hE0);
		wr(8'h1E, 8'hFF);
		rd_chk(8'h1E, 8'h20);
		chk({3'h0, hot_code, hot_en, cold_sel, uv_fix}, 8'h1B);
		wr(8'h21, 8'h00);
		rd_chk(8'h21, {b, 1'b0, ~b[0], b});
		wr(8'h19, 8'h80);
		rd_chk(8'h1C, 8'h57);
		rd_chk(8'h1D, 8'h40);
		rd_chk(8'h1E, 8'h00);
		rd_chk(8'h19, 8'h00);
		chk({3'h0, hot_code, hot_en, cold_sel, uv_fix}, 8'h0C);
		host.start();
		host.xfer(8'h54, 1'b1, d, a);
		host.stop();
		chk({7'h0, a}, 8'h00);
		// Open drain: the data value pin never carries a one
		chk({7'h0, sda_o}, 8'h00);
		$display("test access done");
		tgt(3'h0, 5'h1F, 5'h1F);
		tgt(3'h1, 5'h1F, 5'h1B);
		tgt(3'h2, 5'h13, 5'h11);
		tgt(3'h3, 5'h10, 5'h00);
		tgt(3'h4, 5'h10, 5'h00);
		wr(8'h1C, 8'h03);
		tgt(3'h1, 5'h10, 5'h00);
		tgt(3'h2, 5'h10, 5'h00);
		wr(8'h1C, 8'h7B);
		tgt(3'h1, 5'h1F, 5'h1F);
		tgt(3'h2, 5'h13, 5'h12);
		wr(8'h1C, 8'h2F);
		tgt(3'h1, 5'h1F, 5'h16);
		tgt(3'h2, 5'h13, 5'h13);
		wr(8'h1C, 8'h55);
		tgt(3'h1, 5'h1F, 5'h1F);
		tgt(3'h3, 5'h10, 5'h00);
		wr(8'h1C, 8'h56);
		tgt(3'h3, 5'h1F, 5'h1F);
		chk({6'h0, tme, hot_en}, 8'h00);
		$display("test targets done");
		test_done();
	end
endmodule : tb_battery_temp_and_charge_status_regs
